// file: src/wiu_defs.vh
// constants of the wakeup and interrupt unit
`ifndef WIU_DEFS_VH
`define WIU_DEFS_VH
`define WIU_SEL_PENDING   4'h9
`define WIU_SEL_EDGE      4'ha
`define WIU_SEL_ENABLE    4'hb
`define WIU_SEL_DIR       4'hf
`define WIU_MASK_RST      8'hff
`define WIU_EDGE_RST      8'hff
`define WIU_DIR_RST       8'hff
`define WIU_PC_TOP        11'h7ff
`define WIU_PC_VECTOR     11'h000
`define WIU_CNT_MAX       8'hff
`define WIU_STAT_PD       3
`define WIU_STAT_TO       4
`define WIU_PAGE_CLR      8'h1f
`endif

// file: src/wiu_wakeup_interrupt_unit.v
// port b wakeup, interrupt entry and return for the controller core
`timescale 1ns/1ps
`include "wiu_defs.vh"
module wiu_wakeup_interrupt_unit (
    input  wire        clk,
    input  wire        rst_b,
    input  wire [7:0]  portBPin,
    input  wire        externalResetPin_b,
    input  wire        watchdogEnable,
    input  wire        watchdogOverflow,
    input  wire        powerDownInstr,
    input  wire        ctrlWrite,
    input  wire [3:0]  portConfigSelector,
    input  wire [7:0]  accIn,
    input  wire [10:0] pcIn,
    input  wire [7:0]  statusIn,
    input  wire [7:0]  bankPointerIn,
    input  wire        counterIntEnable,
    input  wire [7:0]  counterIn,
    input  wire        instrBoundary,
    input  wire        retInstr,
    input  wire        retAddInstr,
    output reg         powerDown,
    output reg         watchdogClear,
    output reg         statusFlagWrite,
    output reg         watchdogExpiryFlag,
    output reg         powerDownFlag,
    output reg         accLoad,
    output reg  [7:0]  accOut,
    output reg         pcLoad,
    output reg  [10:0] pcOut,
    output reg         statusLoad,
    output reg  [7:0]  statusOut,
    output reg         bankPointerLoad,
    output reg  [7:0]  bankPointerOut,
    output reg         counterLoad,
    output reg  [7:0]  counterOut,
    output reg         intActive,
    output reg  [7:0]  wakeEnableMask,
    output reg  [7:0]  wakeEdgeSelect,
    output reg  [7:0]  pinDirection,
    output reg  [7:0]  wakePendingLatch
);

    reg  [7:0]  pinMeta;
    reg  [7:0]  pinSync;
    reg  [7:0]  pinPrev;
    reg         rstMeta;
    reg         rstSync_b;
    reg  [7:0]  prevCounter;
    reg         globalIntEnable;
    reg  [10:0] pcStack;
    reg  [7:0]  accShadow;
    reg  [7:0]  statusShadow;
    reg  [7:0]  bankShadow;
    wire [7:0]  riseEv;
    wire [7:0]  fallEv;
    wire [7:0]  edgeHit;
    wire        pinIntReq;
    wire        counterWrap;
    wire        swapAccess;
    wire [7:0]  next_wakePendingLatch;
    wire        takeInt;
    wire        anyReturn;
    wire        wakeSource;
    wire        doWake;
    wire        doSleep;
    wire        doEntry;
    wire        doReturn;
    genvar      i;

    // pin and reset pin synchronisers
    always @(posedge clk) begin
        pinMeta   <= portBPin;
        pinSync   <= pinMeta;
        pinPrev   <= pinSync;
        rstMeta   <= externalResetPin_b;
        rstSync_b <= rstMeta;
    end

    // per pin edge detection on the synchronised level
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_edge
            assign riseEv[i]  = pinSync[i] & ~pinPrev[i];
            assign fallEv[i]  = ~pinSync[i] & pinPrev[i];
            // a set select bit picks the falling edge, a clear one the rising edge
            assign edgeHit[i] = wakeEdgeSelect[i] ? fallEv[i] : riseEv[i];
        end
    endgenerate

    // enabled pins with a latched edge request an interrupt or wakeup
    assign pinIntReq   = |(wakePendingLatch & ~wakeEnableMask);
    assign counterWrap = (prevCounter == `WIU_CNT_MAX) && (counterIn == 8'h00);
    assign swapAccess  = ctrlWrite && (portConfigSelector == `WIU_SEL_PENDING);
    // edges set bits even while a swap writes the latch; set wins
    assign next_wakePendingLatch = (swapAccess ? accIn : wakePendingLatch) | edgeHit;
    assign anyReturn = retInstr | retAddInstr;
    assign takeInt   = !powerDown && globalIntEnable && instrBoundary && !anyReturn
                       && (pinIntReq || (counterWrap && counterIntEnable));

    // one decision per cycle: wake beats sleep, sleep beats entry, return beats entry
    assign wakeSource = !rstSync_b || watchdogOverflow || pinIntReq;
    assign doWake     = powerDown && wakeSource;
    assign doSleep    = !powerDown && powerDownInstr;
    assign doEntry    = !powerDown && !powerDownInstr && takeInt;
    assign doReturn   = !powerDown && !powerDownInstr && anyReturn && intActive;

    // pending latch has no reset term on purpose
    always @(posedge clk) begin
        wakePendingLatch <= next_wakePendingLatch;
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            wakeEnableMask <= `WIU_MASK_RST;
            wakeEdgeSelect <= `WIU_EDGE_RST;
            pinDirection   <= `WIU_DIR_RST;
        end else if (ctrlWrite) begin
            case (portConfigSelector)
                `WIU_SEL_EDGE: begin
                    wakeEdgeSelect <= accIn;
                end
                `WIU_SEL_ENABLE: begin
                    wakeEnableMask <= accIn;
                end
                `WIU_SEL_DIR: begin
                    pinDirection <= accIn;
                end
                default: begin
                end
            endcase
        end
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            prevCounter <= 8'h00;
        end else begin
            prevCounter <= counterIn;
        end
    end

    // core is halted while powerDown is high; only wake sources are watched
    always @(posedge clk) begin
        if (!rst_b) begin
            powerDown <= 1'b0;
        end else if (doWake) begin
            powerDown <= 1'b0;
        end else if (doSleep) begin
            powerDown <= 1'b1;
        end
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            watchdogClear   <= 1'b0;
            statusFlagWrite <= 1'b0;
        end else begin
            watchdogClear   <= doSleep && watchdogEnable;
            statusFlagWrite <= doSleep && watchdogEnable;
        end
    end

    // flags keep their value until the next power-down with watchdog enabled
    always @(posedge clk) begin
        if (!rst_b) begin
            watchdogExpiryFlag <= 1'b0;
            powerDownFlag      <= 1'b1;
        end else if (doSleep && watchdogEnable) begin
            watchdogExpiryFlag <= 1'b1;
            powerDownFlag      <= 1'b0;
        end
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            pcLoad <= 1'b1;
            pcOut  <= `WIU_PC_TOP;
        end else begin
            pcLoad <= doWake || doEntry || doReturn;
            if (doWake) begin
                pcOut <= `WIU_PC_TOP;
            end else if (doEntry) begin
                pcOut <= `WIU_PC_VECTOR;
            end else if (doReturn) begin
                pcOut <= pcStack;
            end
        end
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            statusLoad <= 1'b0;
            statusOut  <= 8'h00;
        end else begin
            statusLoad <= doEntry || doReturn;
            if (doEntry) begin
                statusOut <= statusIn & `WIU_PAGE_CLR;
            end else if (doReturn) begin
                statusOut <= statusShadow;
            end
        end
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            bankPointerLoad <= 1'b0;
            bankPointerOut  <= 8'h00;
        end else begin
            bankPointerLoad <= doReturn;
            if (doReturn) begin
                bankPointerOut <= bankShadow;
            end
        end
    end

    // a swap in the return cycle loses to the restore of the accumulator
    always @(posedge clk) begin
        if (!rst_b) begin
            accLoad <= 1'b0;
            accOut  <= 8'h00;
        end else begin
            accLoad <= swapAccess || doReturn;
            if (doReturn) begin
                accOut <= accShadow;
            end else begin
                accOut <= wakePendingLatch;
            end
        end
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            counterLoad <= 1'b0;
            counterOut  <= 8'h00;
        end else begin
            counterLoad <= doReturn && retAddInstr;
            if (doReturn && retAddInstr) begin
                counterOut <= counterIn + accIn;
            end
        end
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            intActive       <= 1'b0;
            globalIntEnable <= 1'b1;
        end else if (doEntry) begin
            intActive       <= 1'b1;
            globalIntEnable <= 1'b0;
        end else if (doReturn) begin
            intActive       <= 1'b0;
            globalIntEnable <= 1'b1;
        end
    end

    // single-level stack: no second entry can come before a return
    always @(posedge clk) begin
        if (!rst_b) begin
            pcStack      <= 11'h000;
            accShadow    <= 8'h00;
            statusShadow <= 8'h00;
            bankShadow   <= 8'h00;
        end else if (doEntry) begin
            pcStack      <= pcIn;
            accShadow    <= accIn;
            statusShadow <= statusIn;
            bankShadow   <= bankPointerIn;
        end
    end

endmodule

// file: bench/wiu_checker_asserts.sv
// port-level assertions of the wakeup and interrupt unit
`timescale 1ns/1ps
module wiu_checker (
    input logic clk, rst_b, powerDownInstr, watchdogEnable, ctrlWrite, retInstr,
    input logic retAddInstr, powerDown, watchdogClear, statusFlagWrite, watchdogExpiryFlag,
    input logic powerDownFlag, accLoad, pcLoad, statusLoad, counterLoad, intActive,
    input logic [3:0] portConfigSelector,
    input logic [7:0] accIn, statusIn, counterIn, accOut, statusOut, counterOut,
    input logic [7:0] wakeEnableMask, wakeEdgeSelect, wakePendingLatch,
    input logic [10:0] pcOut
);
    logic seen;
    // pending latch has no reset value; trust it only after a first swap
    always @(posedge clk)
        seen <= rst_b && (seen || (ctrlWrite && portConfigSelector == 4'h9));
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_sleep; powerDownInstr |=> powerDown; endproperty
    a_sleep: assert property (p_sleep) else $error("no sleep");
    property p_wdog; powerDownInstr && watchdogEnable |=> watchdogClear && statusFlagWrite
        && watchdogExpiryFlag && !powerDownFlag; endproperty
    a_wdog: assert property (p_wdog) else $error("bad flags");
    property p_wake; $fell(powerDown) |-> pcLoad && pcOut == 11'h7ff; endproperty
    a_wake: assert property (p_wake) else $error("bad wake pc");
    property p_entry; $rose(intActive) |-> pcLoad && pcOut == 11'h000 && statusLoad
        && statusOut == ($past(statusIn) & 8'h1f); endproperty
    a_entry: assert property (p_entry) else $error("bad entry");
    property p_block; intActive && !retInstr && !retAddInstr |=> intActive; endproperty
    a_block: assert property (p_block) else $error("left service");
    property p_retAdd; intActive && retAddInstr |=> counterLoad && !intActive
        && counterOut == $past(counterIn) + $past(accIn); endproperty
    a_retAdd: assert property (p_retAdd) else $error("bad return");
    property p_swap; seen && ctrlWrite && portConfigSelector == 4'h9 |=> accLoad
        && accOut == $past(wakePendingLatch); endproperty
    a_swap: assert property (p_swap) else $error("bad swap");
    property p_edge; ctrlWrite && portConfigSelector == 4'ha |=>
        wakeEdgeSelect == $past(accIn); endproperty
    a_edge: assert property (p_edge) else $error("edge write");
    property p_mask; ctrlWrite && portConfigSelector == 4'hb |=>
        wakeEnableMask == $past(accIn); endproperty
    a_mask: assert property (p_mask) else $error("mask write");
    property p_hold; seen && !(ctrlWrite && portConfigSelector == 4'h9) |=>
        (wakePendingLatch & $past(wakePendingLatch)) == $past(wakePendingLatch); endproperty
    a_hold: assert property (p_hold) else $error("pending lost");
    c_sleep: cover property (powerDown ##1 !powerDown);
    c_int: cover property ($rose(intActive));
    c_ret: cover property (intActive ##1 !intActive);
endmodule
bind wiu_wakeup_interrupt_unit wiu_checker u_wiu_checker (.*);

// file: bench/wiu_pin_model.sv
// port b pin model: levels change only away from the sampling edge
`timescale 1ns/1ps
module wiu_pin_model (
    input  logic       clk,
    input  logic [7:0] pinLevel,
    output logic [7:0] portBPin
);
    initial portBPin = 8'h00;
    always @(negedge clk) portBPin <= pinLevel;
endmodule

// file: bench/tb_wiu_wakeup_interrupt_unit.sv
// self-checking bench of the wakeup and interrupt unit
`timescale 1ns/1ps
module tb_wiu_wakeup_interrupt_unit;
    logic clk = 0, rst_b = 0, externalResetPin_b = 1, watchdogEnable = 0, watchdogOverflow = 0;
    logic powerDownInstr = 0, ctrlWrite = 0, counterIntEnable = 0, instrBoundary = 1;
    logic retInstr = 0, retAddInstr = 0, powerDown, watchdogClear, statusFlagWrite;
    logic watchdogExpiryFlag, powerDownFlag, accLoad, pcLoad, statusLoad, bankPointerLoad;
    logic counterLoad, intActive;
    logic [3:0] portConfigSelector = 0;
    logic [7:0] portBPin, pinLevel = 0, accIn = 0, statusIn = 8'he5, bankPointerIn = 8'h44;
    logic [7:0] counterIn = 0, accOut, statusOut, bankPointerOut, counterOut;
    logic [7:0] wakeEnableMask, wakeEdgeSelect, pinDirection, wakePendingLatch;
    logic [10:0] pcIn = 11'h123, pcOut;
    int errCount = 0, checks = 0;
    wiu_wakeup_interrupt_unit u_wiu_wakeup_interrupt_unit (.*);
    wiu_pin_model u_wiu_pin_model (.clk(clk), .pinLevel(pinLevel), .portBPin(portBPin));
    task chk(input logic [10:0] got, exp);
        checks++;
        if (got !== exp) begin
            errCount++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task ctl(input logic [3:0] sel, input logic [7:0] d);
        @(negedge clk);
        portConfigSelector = sel;
        accIn = d;
        ctrlWrite = 1;
        @(negedge clk);
        ctrlWrite = 0;
    endtask
    // k: 0 sleep, 1 return, 2 return with add, 3 watchdog overflow
    task pls(input int k);
        @(negedge clk);
        {watchdogOverflow, retAddInstr, retInstr, powerDownInstr} = 4'b1 << k;
        @(negedge clk);
        {watchdogOverflow, retAddInstr, retInstr, powerDownInstr} = 4'b0;
    endtask
    // waits for intActive (pd 0) or powerDown (pd 1) to reach lvl
    task wt(input logic pd, lvl);
        int n;
        n = 0;
        while ((pd ? powerDown : intActive) !== lvl && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk(n < 20, 1'b1);
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", checks, errCount);
        if (errCount == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial forever #25 clk = ~clk;
    initial begin
        #(3000 * 50);
        errCount++;
        end_of_test();
    end
    initial begin
        repeat (2) @(negedge clk);
        chk(wakeEnableMask, 8'hff);
        chk(wakeEdgeSelect, 8'hff);
        chk(pcOut, 11'h7ff);
        rst_b = 1;
        ctl(4'hf, 8'h07);
        chk(pinDirection, 8'h07);
        ctl(4'ha, 8'h02);
        chk(wakeEdgeSelect, 8'h02);
        ctl(4'h9, 8'h00);
        chk(wakePendingLatch, 8'h00);
        ctl(4'hb, 8'hfc);
        chk(wakeEnableMask, 8'hfc);
        pinLevel = 8'h06;
        repeat (8) @(negedge clk);
        chk(wakePendingLatch, 8'h04);
        chk(intActive, 1'b0);
        ctl(4'h9, 8'h00);
        chk(accOut, 8'h04);
        $display("config test done");
        pinLevel = 8'h07;
        wt(0, 1);
        chk(pcOut, 11'h000);
        chk(statusOut, 8'h05);
        pinLevel = 8'h05;
        repeat (8) @(negedge clk);
        chk(wakePendingLatch, 8'h03);
        chk(intActive, 1'b1);
        ctl(4'h9, 8'h00);
        counterIn = 8'h20;
        accIn = 8'h10;
        pls(2);
        chk(pcOut, 11'h123);
        chk({pcLoad, statusLoad, bankPointerLoad, accLoad, counterLoad}, 5'h1f);
        chk(statusOut, 8'he5);
        chk(accOut, 8'h00);
        chk(counterOut, 8'h30);
        chk(bankPointerOut, 8'h44);
        chk(intActive, 1'b0);
        counterIntEnable = 1;
        counterIn = 8'hff;
        repeat (2) @(negedge clk);
        chk(intActive, 1'b0);
        counterIn = 8'h00;
        wt(0, 1);
        pls(1);
        chk(intActive, 1'b0);
        $display("interrupt test done");
        counterIntEnable = 0;
        watchdogEnable = 1;
        pls(0);
        chk({powerDown, watchdogClear, statusFlagWrite, watchdogExpiryFlag, powerDownFlag}, 5'h1e);
        repeat (3) @(negedge clk);
        chk(powerDown, 1'b1);
        pls(3);
        chk(powerDown, 1'b0);
        chk(pcLoad, 1'b1);
        chk(pcOut, 11'h7ff);
        watchdogEnable = 0;
        pls(0);
        pinLevel = 8'h04;
        repeat (4) @(negedge clk);
        pinLevel = 8'h05;
        wt(1, 0);
        chk(pcOut, 11'h7ff);
        $display("power-down test done");
        end_of_test();
    end
endmodule
